// [cpcr_bitorder.sv]
// byte lane reorder: passes a byte straight or bit-reversed
module cpcr_bitorder
    import cpcr_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] data_in,
    input  wire logic             reverse_in,
    output logic      [WIDTH-1:0] data_out
);
    logic [WIDTH-1:0] rev_w;
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            rev_w[i] = data_in[WIDTH-1-i];
        end
    end
    assign data_out = reverse_in ? rev_w : data_in;
endmodule : cpcr_bitorder

// [cpcr_pkg.sv]
// package: register map, field positions and types for the converter port config bank
package cpcr_pkg;
    localparam logic [14:0] CPCR_OFF_SETUP_PRI  = 15'h0000;
    localparam logic [14:0] CPCR_OFF_SETUP_SEC  = 15'h0001;
    localparam logic [14:0] CPCR_OFF_POWER      = 15'h0002;
    localparam logic [14:0] CPCR_OFF_TYPE       = 15'h0003;
    localparam int          CPCR_BIT_SRST       = 0;
    localparam int          CPCR_BIT_LSBF       = 1;
    localparam int          CPCR_BIT_ASC        = 2;
    localparam int          CPCR_BIT_ASC_M      = 5;
    localparam int          CPCR_BIT_LSBF_M     = 6;
    localparam int          CPCR_BIT_SRST_M     = 7;
    localparam int          CPCR_BIT_DP_RST     = 1;
    localparam logic [7:0]  CPCR_RST_VAL        = 8'h00;
    localparam logic [7:0]  CPCR_ZERO_BYTE      = 8'h00;
    localparam logic [14:0] CPCR_ADDR_STEP      = 15'h0001;
    localparam logic [2:0]  CPCR_BIT_LAST       = 3'h7;
    localparam logic [2:0]  CPCR_BIT_FIRST      = 3'h0;
    localparam logic [4:0]  CPCR_INSTR_BITS     = 5'h10;
    localparam logic [4:0]  CPCR_CNT_ZERO       = 5'h00;
    localparam logic [4:0]  CPCR_CNT_ONE        = 5'h01;
    localparam logic [1:0]  CPCR_PM_NORMAL      = 2'h0;
    localparam logic [1:0]  CPCR_PM_STANDBY     = 2'h2;
    localparam logic [1:0]  CPCR_PM_POWERDOWN   = 2'h3;
    typedef enum logic [1:0] {
        CPCR_ST_INSTR = 2'b00,
        CPCR_ST_WRITE = 2'b01,
        CPCR_ST_READ  = 2'b10
    } cpcr_state_type;
    typedef struct packed {
        logic       lsb_first;
        logic       addr_ascend;
        logic [1:0] power_mode;
    } cpcr_cfg_type;
    typedef struct packed {
        logic dp_clk_en;
        logic dp_reset;
        logic link_en;
    } cpcr_gate_type;
endpackage : cpcr_pkg

// [cpcr_regs.sv]
// configuration register bank with three-wire serial port, power-mode gating
// Functional notes
// RULE1: writing 1 to bit 0 at 0x0000 resets port and registers; bit self-clears
// RULE2: host waits 5 ms after soft reset before writing other registers
// RULE3: bits 7,6,5 mirror bits 0,1,2; reset mirror also self-clears
// RULE4: bit-order control 1 shifts lsb first, 0 msb first; resets to 0
// RULE5: multibyte address decrements when direction 0, increments when 1
// RULE6: bit 1 at 0x0001 resets only datapath, then self-clears
// RULE7: power mode 00 normal; 10 stops datapath clocks, link stays on
// RULE8: power mode 11 stops clocks, holds datapath reset, disables link
// RULE9: host never writes undefined register addresses
// RULE10: host resets by writing 0x81 so either bit order works
// RULE11: reserved bits read zero and ignore writes
module cpcr_regs
    import cpcr_pkg::*;
#(
    parameter logic [7:0] TYPE_CODE = 8'h5a  // arbitrary value
) (
    input  wire logic            clk_sys_in,
    input  wire logic            resetn_in,
    input  wire logic            sclk_in,
    input  wire logic            csn_in,
    input  wire logic            sdio_in,
    output logic                 sdio_out,
    output logic                 sdio_oe_out,
    output cpcr_pkg::cpcr_cfg_type  cfg_out,
    output cpcr_pkg::cpcr_gate_type gate_out,
    output logic                 dp_soft_reset_out
);
    import cpcr_pkg::*;

    // serial clock sampled in the system domain; edges found by history compare
    logic            sclk_d_r;
    cpcr_state_type  state_r, state_nxt;
    logic [4:0]      cnt_r, cnt_nxt;
    logic [15:0]     instr_r, instr_nxt;
    logic [7:0]      shift_r, shift_nxt;
    logic [14:0]     addr_r, addr_nxt;
    logic [2:0]      bit_r, bit_nxt;
    logic            lsbf_r, lsbf_nxt;
    logic            asc_r, asc_nxt;
    logic [1:0]      pm_r, pm_nxt;
    logic            srst_r, srst_nxt;
    logic            dprst_r, dprst_nxt;
    logic            sdo_r, sdo_nxt;
    logic            oe_r, oe_nxt;
    cpcr_gate_type   gate_r, gate_nxt;

    wire rise_w = sclk_in & ~sclk_d_r;
    wire fall_w = ~sclk_in & sclk_d_r;
    wire active_w = ~csn_in;

    // byte assembled in wire order, then reordered to register order
    wire [7:0] wr_byte_raw_w = {shift_r[6:0], sdio_in};
    wire [7:0] wr_byte_w;
    cpcr_bitorder #(.WIDTH(8)) u_wr_order (
        .data_in    (wr_byte_raw_w),
        .reverse_in (lsbf_r),       // RULE4
        .data_out   (wr_byte_w)
    );

    // readback mux; reserved bits come back as zero
    wire [7:0] rd_pri_w = {1'b0, lsbf_r, asc_r, 2'b00, asc_r, lsbf_r, 1'b0}; // RULE3 RULE11
    wire [7:0] rd_sec_w = CPCR_ZERO_BYTE; // RULE11
    wire [7:0] rd_pow_w = {6'b000000, pm_r}; // RULE11
    wire       hit_pri_w = (addr_r == CPCR_OFF_SETUP_PRI);
    wire       hit_sec_w = (addr_r == CPCR_OFF_SETUP_SEC);
    wire       hit_pow_w = (addr_r == CPCR_OFF_POWER);
    wire       hit_typ_w = (addr_r == CPCR_OFF_TYPE);
    wire [7:0] rd_data_w = hit_pri_w ? rd_pri_w :
                           hit_sec_w ? rd_sec_w :
                           hit_pow_w ? rd_pow_w :
                           hit_typ_w ? TYPE_CODE : CPCR_ZERO_BYTE;
    wire [7:0] rd_wire_w;
    cpcr_bitorder #(.WIDTH(8)) u_rd_order (
        .data_in    (rd_data_w),
        .reverse_in (lsbf_r),       // RULE4
        .data_out   (rd_wire_w)
    );

    wire [14:0] addr_step_w = asc_r ? addr_r + CPCR_ADDR_STEP
                                    : addr_r - CPCR_ADDR_STEP; // RULE5
    // either reset bit or its mirror triggers, so 0x81 works in both orders
    wire srst_req_w = wr_byte_w[CPCR_BIT_SRST] | wr_byte_w[CPCR_BIT_SRST_M]; // RULE1 RULE3
    // a write to bit 2 or 5 sets direction, same for bit order; ors the copies
    wire asc_wr_w  = wr_byte_w[CPCR_BIT_ASC]  | wr_byte_w[CPCR_BIT_ASC_M];   // RULE3
    wire lsbf_wr_w = wr_byte_w[CPCR_BIT_LSBF] | wr_byte_w[CPCR_BIT_LSBF_M];  // RULE3
    wire byte_done_w = rise_w && (bit_r == CPCR_BIT_LAST);
    wire instr_done_w = rise_w && (cnt_r == CPCR_CNT_ONE);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        instr_nxt = instr_r;
        shift_nxt = shift_r;
        addr_nxt  = addr_r;
        bit_nxt   = bit_r;
        lsbf_nxt  = lsbf_r;
        asc_nxt   = asc_r;
        pm_nxt    = pm_r;
        srst_nxt  = 1'b0;   // RULE1
        dprst_nxt = 1'b0;   // RULE6
        sdo_nxt   = sdo_r;
        oe_nxt    = oe_r;
        if (!active_w) begin
            state_nxt = CPCR_ST_INSTR;
            cnt_nxt   = CPCR_INSTR_BITS;
            bit_nxt   = CPCR_BIT_FIRST;
            oe_nxt    = 1'b0;
        end else begin
            unique case (state_r)
                CPCR_ST_INSTR: begin
                    // instruction word is always msb first: r/w then 15-bit address
                    if (rise_w) begin
                        instr_nxt = {instr_r[14:0], sdio_in};
                        cnt_nxt   = cnt_r - CPCR_CNT_ONE;
                    end
                    if (instr_done_w) begin
                        addr_nxt  = {instr_r[13:0], sdio_in};
                        bit_nxt   = CPCR_BIT_FIRST;
                        state_nxt = instr_r[14] ? CPCR_ST_READ : CPCR_ST_WRITE;
                        cnt_nxt   = CPCR_CNT_ZERO;
                    end
                end
                CPCR_ST_WRITE: begin
                    if (rise_w) begin
                        shift_nxt = wr_byte_raw_w;
                        bit_nxt   = bit_r + 3'h1;
                    end
                    if (byte_done_w) begin
                        addr_nxt = addr_step_w;
                        // undefined and read-only addresses ignore the byte
                        if (hit_pri_w) begin
                            lsbf_nxt = lsbf_wr_w;  // RULE4
                            asc_nxt  = asc_wr_w;   // RULE5
                            srst_nxt = srst_req_w; // RULE1
                        end
                        if (hit_sec_w) begin
                            dprst_nxt = wr_byte_w[CPCR_BIT_DP_RST]; // RULE6
                        end
                        if (hit_pow_w) begin
                            pm_nxt = wr_byte_w[1:0]; // RULE11
                        end
                    end
                end
                CPCR_ST_READ: begin
                    // data driven on falling edges, host samples on rising
                    if (fall_w) begin
                        oe_nxt  = 1'b1;
                        sdo_nxt = rd_wire_w[CPCR_BIT_LAST - bit_r];
                    end
                    if (rise_w) begin
                        bit_nxt = bit_r + 3'h1;
                    end
                    if (byte_done_w) begin
                        addr_nxt = addr_step_w; // RULE5
                    end
                end
                default: begin
                    state_nxt = CPCR_ST_INSTR;
                end
            endcase
        end
        // soft reset wins over everything, including the byte just written
        if (srst_r) begin
            lsbf_nxt  = 1'b0;
            asc_nxt   = 1'b0;
            pm_nxt    = CPCR_PM_NORMAL;
            state_nxt = CPCR_ST_INSTR;
            cnt_nxt   = CPCR_INSTR_BITS;
            oe_nxt    = 1'b0;
        end
    end

    // gating from power mode; standby (10) keeps link, powerdown (11) drops it
    always_comb begin
        gate_nxt.dp_clk_en = (pm_r == CPCR_PM_NORMAL) ||
                             (pm_r != CPCR_PM_STANDBY && pm_r != CPCR_PM_POWERDOWN); // RULE7
        gate_nxt.dp_reset  = (pm_r == CPCR_PM_POWERDOWN) || dprst_r;                 // RULE8
        gate_nxt.link_en   = (pm_r != CPCR_PM_POWERDOWN);                            // RULE8
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_d_r <= 1'b0;
            state_r  <= CPCR_ST_INSTR;
            cnt_r    <= CPCR_INSTR_BITS;
            instr_r  <= '0;
            shift_r  <= CPCR_RST_VAL;
            addr_r   <= '0;
            bit_r    <= CPCR_BIT_FIRST;
            lsbf_r   <= 1'b0;
            asc_r    <= 1'b0;
            pm_r     <= CPCR_PM_NORMAL;
            srst_r   <= 1'b0;
            dprst_r  <= 1'b0;
            sdo_r    <= 1'b0;
            oe_r     <= 1'b0;
            gate_r   <= '0;
        end else begin
            sclk_d_r <= sclk_in;
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            instr_r  <= instr_nxt;
            shift_r  <= shift_nxt;
            addr_r   <= addr_nxt;
            bit_r    <= bit_nxt;
            lsbf_r   <= lsbf_nxt;
            asc_r    <= asc_nxt;
            pm_r     <= pm_nxt;
            srst_r   <= srst_nxt;
            dprst_r  <= dprst_nxt;
            sdo_r    <= sdo_nxt;
            oe_r     <= oe_nxt;
            gate_r   <= gate_nxt;
        end
    end

    assign sdio_out          = sdo_r;
    assign sdio_oe_out       = oe_r;
    assign cfg_out           = '{lsb_first: lsbf_r, addr_ascend: asc_r, power_mode: pm_r};
    assign gate_out          = gate_r;
    assign dp_soft_reset_out = dprst_r; // RULE6
endmodule : cpcr_regs

// [cpcr_regs_asserts.sv]
// checker: port-level properties of the config bank
module cpcr_regs_chk
    import cpcr_pkg::*;
(
    input wire logic                    clk_sys_in,
    input wire logic                    resetn_in,
    input wire logic                    csn_in,
    input wire logic                    sdio_oe_out,
    input wire cpcr_pkg::cpcr_cfg_type  cfg_out,
    input wire cpcr_pkg::cpcr_gate_type gate_out,
    input wire logic                    dp_soft_reset_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    // a datapath soft reset pulse shows up in the gate's reset bit one cycle later
    a_gate_normal: assert property (
        !cfg_out.power_mode[1] |=> gate_out == {1'b1, $past(dp_soft_reset_out), 1'b1})
        else $error("gate not normal");
    a_gate_standby: assert property (
        cfg_out.power_mode == CPCR_PM_STANDBY |=>
        gate_out == {1'b0, $past(dp_soft_reset_out), 1'b1})
        else $error("gate not standby");
    a_gate_off: assert property (cfg_out.power_mode == CPCR_PM_POWERDOWN |=> gate_out == 3'h2)
        else $error("gate not powered down");
    a_dprst_pulse: assert property (dp_soft_reset_out |=> !dp_soft_reset_out)
        else $error("datapath reset longer than one cycle");
    a_oe_needs_cs: assert property (sdio_oe_out |-> !$past(csn_in))
        else $error("sdio driven without select");
    a_oe_idle: assert property (csn_in |=> !sdio_oe_out)
        else $error("sdio driven after deselect");
    a_oe_instr_quiet: assert property ($fell(csn_in) |=> !sdio_oe_out [*8])
        else $error("sdio driven in instruction phase");
    a_cfg_idle_stable: assert property (csn_in [*3] |=> $stable(cfg_out))
        else $error("config moved while idle");
endmodule : cpcr_regs_chk

// [cpcr_spi_host.sv]
// spi host model: three-wire frames with bit order and turnaround
module cpcr_spi_host #(
    parameter int SRST_WAIT = 40  // stands in for the recovery wait, shortened for run time
) (
    input  wire logic clk_in,
    input  wire logic sdio_line_in,
    output logic      sclk_out,
    output logic      csn_n_out,
    output logic      sdio_drv_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rdat [4];
    initial begin
        sclk_out = 1'b0;
        csn_n_out = 1'b1;
        sdio_drv_out = 1'b0;
    end
    task automatic bitx(input logic b, input logic drv, output logic s);
        @(negedge clk_in);
        sclk_out = 1'b0;
        sdio_drv_out = drv ? b : ~sdio_drv_out;  // not driving: inverts its last value, so no stale bit is left on the line
        repeat (3) @(negedge clk_in);
        sclk_out = 1'b1;
        s = sdio_line_in;
        @(negedge clk_in);
    endtask : bitx
    task automatic frame(input logic rd, input logic [14:0] a, input int n, input logic lsbf,
                         input logic [7:0] wd [4]);
        logic        s;
        logic [15:0] ins;
        int          j;
        ins = {rd, a};  // instruction always msb first
        @(negedge clk_in);
        csn_n_out = 1'b0;
        for (int i = 15; i >= 0; i--) bitx(ins[i], 1'b1, s);
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                j = lsbf ? i : 7 - i;
                bitx(wd[k][j], !rd, s);
                rdat[k][j] = s;
            end
        end
        @(negedge clk_in);
        csn_n_out = 1'b1;
        @(negedge clk_in);
        sclk_out = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask : frame
    task automatic settle();
        repeat (SRST_WAIT) @(negedge clk_in);
    endtask : settle
endmodule : cpcr_spi_host

// [tb_converter_port_config_regs.sv]
// testbench: converter port config bank through its serial port
module tb_converter_port_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import cpcr_pkg::*;
    localparam logic [7:0] TYPE_V = 8'ha6;  // arbitrary value
    logic          clk_sys_in, resetn_in, sclk, csn, host_sd, sd_out, sd_oe, dp_rst, lsbf;
    cpcr_cfg_type  cfg;
    cpcr_gate_type gate;
    wire logic     sd_line = sd_oe ? sd_out : host_sd;
    int            bad_count, tests_run, pulses;
    logic [31:0]   seed;
    logic [7:0]    wd [4];
    logic [7:0]    v;
    cpcr_regs #(.TYPE_CODE(TYPE_V)) u_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .sclk_in(sclk), .csn_in(csn), .sdio_in(sd_line), .sdio_out(sd_out), .sdio_oe_out(sd_oe),
        .cfg_out(cfg), .gate_out(gate), .dp_soft_reset_out(dp_rst));
    cpcr_spi_host #(.SRST_WAIT(40)) u_host (.clk_in(clk_sys_in), .sdio_line_in(sd_line),
        .sclk_out(sclk), .csn_n_out(csn), .sdio_drv_out(host_sd));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    function automatic cpcr_gate_type gate_exp(input logic [1:0] pm);
        return '{dp_clk_en: !pm[1], dp_reset: pm == CPCR_PM_POWERDOWN,
                 link_en: pm != CPCR_PM_POWERDOWN};
    endfunction : gate_exp
    task automatic fail(input string m);
        bad_count++;
        $display("mismatch at %0t: %s", $time, m);
    endtask : fail
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) fail($sformatf("byte got %h expected %h", g, e));
    endtask : cmp8
    task automatic cmp_st(input cpcr_cfg_type e);
        tests_run++;
        if (cfg !== e || gate !== gate_exp(e.power_mode)) fail("config or gate state");
    endtask : cmp_st
    task automatic wr(input logic [14:0] a, input int n);
        u_host.frame(1'b0, a, n, lsbf, wd);
    endtask : wr
    task automatic rd(input logic [14:0] a, input int n);
        u_host.frame(1'b1, a, n, lsbf, wd);
    endtask : rd
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    always @(posedge clk_sys_in) if (dp_rst === 1'b1) pulses++;
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (40000) @(posedge clk_sys_in);
        fail("run timed out");
        final_report();
    end
    initial begin
        bad_count = 0;
        tests_run = 0;
        pulses = 0;
        seed = 32'd28677;
        lsbf = 1'b0;
        resetn_in = 1'b0;
        wd = '{default: 8'h00};
        repeat (5) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        rd(15'h0003, 4);
        cmp8(u_host.rdat[0], TYPE_V);
        for (int k = 1; k < 4; k++) cmp8(u_host.rdat[k], CPCR_RST_VAL);
        cmp_st('0);
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            v = (i < 4) ? ((8'h78 >> (2 * i)) & 8'h03) : seed[7:0];
            wd[0] = v;
            wr(CPCR_OFF_POWER, 1);
            cmp_st({2'b00, v[1:0]});
            rd(CPCR_OFF_POWER, 1);
            cmp8(u_host.rdat[0], v & 8'h03);
        end
        wd[0] = ~TYPE_V;
        wr(CPCR_OFF_TYPE, 1);
        rd(CPCR_OFF_TYPE, 1);
        cmp8(u_host.rdat[0], TYPE_V);
        $display("test power modes done");
        pulses = 0;
        wd[0] = 8'h02;
        wd[1] = 8'h03;
        wr(CPCR_OFF_POWER, 2);
        cmp8(8'(pulses), 8'h01);
        cmp_st({2'b00, 2'h2});
        rd(CPCR_OFF_SETUP_SEC, 1);
        cmp8(u_host.rdat[0], 8'h00);
        $display("test datapath reset done");
        wd[0] = 8'h42;
        wr(CPCR_OFF_SETUP_PRI, 1);
        lsbf = 1'b1;
        cmp_st({2'b10, 2'h2});
        rd(CPCR_OFF_SETUP_PRI, 1);
        cmp8(u_host.rdat[0], 8'h42);
        wd[0] = 8'h03;
        wr(CPCR_OFF_POWER, 1);
        cmp_st({2'b10, 2'h3});
        wd[0] = 8'h66;
        wr(CPCR_OFF_SETUP_PRI, 1);
        rd(CPCR_OFF_SETUP_SEC, 2);
        cmp8(u_host.rdat[0], CPCR_ZERO_BYTE);
        cmp8(u_host.rdat[1], 8'h03);
        cmp_st({2'b11, 2'h3});
        $display("test bit order and direction done");
        wd[0] = 8'h80;
        wr(CPCR_OFF_SETUP_PRI, 1);
        lsbf = 1'b0;
        u_host.settle();
        cmp_st('0);
        wd[0] = 8'h02;
        wr(CPCR_OFF_POWER, 1);
        wd[0] = 8'h81;
        wr(CPCR_OFF_SETUP_PRI, 1);
        u_host.settle();
        cmp_st('0);
        rd(CPCR_OFF_SETUP_PRI, 1);
        cmp8(u_host.rdat[0], 8'h00);
        $display("test soft reset done");
        wd[0] = 8'h03;
        wr(CPCR_OFF_POWER, 1);
        cmp_st({2'b00, 2'h3});
        resetn_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        cmp_st('0);
        rd(CPCR_OFF_POWER, 1);
        cmp8(u_host.rdat[0], 8'h00);
        $display("test mid-run reset done");
        final_report();
    end
endmodule : tb_converter_port_config_regs
bind cpcr_regs cpcr_regs_chk u_chk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .csn_in(csn_in), .sdio_oe_out(sdio_oe_out), .cfg_out(cfg_out), .gate_out(gate_out),
    .dp_soft_reset_out(dp_soft_reset_out));
